// file: pkg/vih_consts.svh
// Constants of the vectored interrupt handler
// Function
// R01 - Twelve sources, each assignable to a low or high priority level.
// R02 - A source's valid request event sets its pending flag to one.
// R03 - Pending flags are set whether or not the source is enabled.
// R04 - Enabled set flag: after current instruction, force call to fixed routine address.
// R05 - Return resumes the instruction that would have followed without the request.
// R06 - Every service routine must end with the return-from-interrupt instruction.
// R07 - Disabled sources are ignored for requests; program flow continues undisturbed.
// R08 - Each source has its own enable bit in primary or extended enable register.
// R09 - Individual enables act only while the global enable, bit 7, is one.
// R10 - Global enable at zero blocks every request regardless of individual enables.
// R11 - Events during global disable stay pending and are serviced once re-enabled.
// R12 - Some flags clear by hardware on vectoring; others software clears before return.
// R13 - Flag still set after return re-enters after one further instruction.
// R14 - Software writing one to a pending flag acts like a hardware event.
// R15 - High priority preempts a low routine; a high routine is never preempted.
// R16 - Simultaneous requests resolve by level, then by fixed source order.
// R17 - Requests sampled each cycle; detection takes one cycle, forced call four.
// R18 - Equal or higher running routine delays new request until return plus one.
// R19 - Reserved slots have no flag and never request or vector.
`ifndef VIH_CONSTS_SVH
`define VIH_CONSTS_SVH

`define VIH_NSLOT        15
`define VIH_VALID_MASK   15'h5CFF
`define VIH_HWCLR_MASK   15'h000F
`define VIH_VEC_BASE     16'h0003
`define VIH_VEC_SHIFT    3
`define VIH_GLB_BIT      7
`define VIH_CALL_CYC     3'h4

`define VIH_OFF_PRI_EN   8'h00
`define VIH_OFF_EXT_EN   8'h01
`define VIH_OFF_PRI_PRIO 8'h02
`define VIH_OFF_EXT_PRIO 8'h03
`define VIH_OFF_PSET_LO  8'h04
`define VIH_OFF_PSET_HI  8'h05
`define VIH_OFF_PCLR_LO  8'h06
`define VIH_OFF_PCLR_HI  8'h07
`define VIH_OFF_EVT_STAT 8'h08
`define VIH_OFF_EVT_MASK 8'h09
`define VIH_OFF_SVC_STAT 8'h0A

`define VIH_RST_BYTE     8'h00
`define VIH_RST_EVT      3'h0

`define VIH_EVT_LO_BIT   0
`define VIH_EVT_HI_BIT   1
`define VIH_EVT_PRE_BIT  2

`endif

// file: pkg/vih_pkg.sv
// Types and helpers of the vectored interrupt handler
`include "vih_consts.svh"
package vih_pkg;
  typedef enum {VIH_IDLE, VIH_CALL} vih_state_e;
  typedef logic [`VIH_NSLOT-1:0] vih_slots_t;

  function automatic vih_slots_t vih_slot_bit(input logic [3:0] idx);
    vih_slots_t s;
    s = '0;
    if (idx < 4'hF) begin
      s[idx] = 1'b1;
    end
    return s;
  endfunction : vih_slot_bit
endpackage : vih_pkg

// file: src/vih_arb.sv
// Priority resolver choosing the next source to vector
`timescale 1ns/1ps
module vih_arb
  import vih_pkg::*;
(
  input  wire vih_slots_t pend_i,
  input  wire vih_slots_t en_i,
  input  wire vih_slots_t prio_i,
  input  wire logic       glb_i,
  input  wire logic       act_hi_i,
  input  wire logic       act_lo_i,
  output logic            valid_o,
  output logic [3:0]      idx_o,
  output logic            hi_o
);
  // Lowest index wins among equal levels
  function automatic logic [4:0] vih_pick(input vih_slots_t s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = `VIH_NSLOT - 1; i >= 0; i--) begin
      if (s[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : vih_pick

  vih_slots_t elig;
  logic [4:0] pick_hi;
  logic [4:0] pick_lo;

  always_comb begin
    elig    = pend_i & en_i & `VIH_VALID_MASK & {`VIH_NSLOT{glb_i}}; // [R07] [R09] [R10] [R19]
    pick_hi = vih_pick(elig & prio_i);                                // [R16]
    pick_lo = vih_pick(elig & ~prio_i);
    valid_o = 1'b0;
    idx_o   = 4'h0;
    hi_o    = 1'b0;
    if (!act_hi_i) begin                                              // [R15] [R18]
      if (pick_hi[4]) begin
        valid_o = 1'b1;
        idx_o   = pick_hi[3:0];
        hi_o    = 1'b1;
      end else if (!act_lo_i && pick_lo[4]) begin
        valid_o = 1'b1;
        idx_o   = pick_lo[3:0];
      end
    end
  end
endmodule : vih_arb

// file: src/vih_top.sv
// Vectored interrupt handler: flags, enables, priority and forced call
`timescale 1ns/1ps
module vih_top
  import vih_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic [14:0] SRC_EVT_I,
  input  wire logic        INSTR_DONE_I,
  input  wire logic        RETURN_FROM_INTERRUPT_OP_I,
  output logic             CALL_O,
  output logic      [15:0] CALL_ADDR_O,
  output logic      [14:0] PEND_O,
  output logic             IRQ_O
);
  logic [7:0]  pri_en_r;
  logic [7:0]  ext_en_r;
  logic [7:0]  pri_prio_r;
  logic [7:0]  ext_prio_r;
  vih_slots_t  pend_r;
  vih_slots_t  pend_nxt;
  logic [2:0]  evt_stat_r;
  logic [2:0]  evt_stat_nxt;
  logic [2:0]  evt_mask_r;
  logic        act_hi_r;
  logic        act_lo_r;
  vih_state_e  state_r;
  logic [2:0]  call_cnt_r;
  logic        call_r;
  logic [15:0] call_addr_r;
  logic [3:0]  last_idx_r;
  logic [7:0]  rdata_r;
  logic        req_valid_r;
  logic [3:0]  req_idx_r;
  logic        req_hi_r;

  vih_slots_t  en_slots;
  vih_slots_t  prio_slots;
  vih_slots_t  req_bit;
  logic        glb;
  logic        arb_valid;
  logic [3:0]  arb_idx;
  logic        arb_hi;
  logic        still_ok;
  logic        grant;
  logic        pclr_wr;

  // Slot i maps to primary bit i for 0..6 and extended bit i-7 above
  assign en_slots   = {ext_en_r, pri_en_r[6:0]} & `VIH_VALID_MASK;   // [R01] [R08]
  assign prio_slots = {ext_prio_r, pri_prio_r[6:0]} & `VIH_VALID_MASK;
  assign glb        = pri_en_r[`VIH_GLB_BIT];                        // [R09]
  assign req_bit    = vih_slot_bit(req_idx_r);
  assign pclr_wr    = WR_I && (ADDR_I == `VIH_OFF_PCLR_LO || ADDR_I == `VIH_OFF_PCLR_HI);

  vih_arb i_vih_arb (
    .pend_i   (pend_r),
    .en_i     (en_slots),
    .prio_i   (prio_slots),
    .glb_i    (glb),
    .act_hi_i (act_hi_r),
    .act_lo_i (act_lo_r),
    .valid_o  (arb_valid),
    .idx_o    (arb_idx),
    .hi_o     (arb_hi)
  );

  // Detection stage, resampled every cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      req_valid_r <= 1'b0;
      req_idx_r   <= 4'h0;
      req_hi_r    <= 1'b0;
    end else begin
      req_valid_r <= arb_valid;                                      // [R17]
      req_idx_r   <= arb_idx;
      req_hi_r    <= arb_hi;
    end
  end

  // Winner must still be pending and enabled when the call is forced
  assign still_ok = glb && ((req_bit & en_slots & pend_r) != '0);
  // The return instruction itself never launches a call; the next one may
  assign grant = (state_r == VIH_IDLE) && req_valid_r && still_ok
                 && INSTR_DONE_I && !RETURN_FROM_INTERRUPT_OP_I;                         // [R04] [R13] [R18]

  // Enable and priority registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pri_en_r   <= `VIH_RST_BYTE;
      ext_en_r   <= `VIH_RST_BYTE;
      pri_prio_r <= `VIH_RST_BYTE;
      ext_prio_r <= `VIH_RST_BYTE;
    end else if (WR_I) begin
      if (ADDR_I == `VIH_OFF_PRI_EN) begin
        pri_en_r <= WDATA_I;                                         // [R08] [R09]
      end
      if (ADDR_I == `VIH_OFF_EXT_EN) begin
        ext_en_r <= WDATA_I;
      end
      if (ADDR_I == `VIH_OFF_PRI_PRIO) begin
        pri_prio_r <= WDATA_I;                                       // [R01]
      end
      if (ADDR_I == `VIH_OFF_EXT_PRIO) begin
        ext_prio_r <= WDATA_I;
      end
    end
  end

  // Pending flags; sets are applied last so they win over any clear
  always_comb begin
    pend_nxt = pend_r;
    if (grant) begin
      pend_nxt = pend_nxt & ~(req_bit & `VIH_HWCLR_MASK);            // [R12]
    end
    if (WR_I && ADDR_I == `VIH_OFF_PCLR_LO) begin
      pend_nxt[7:0] = pend_nxt[7:0] & ~WDATA_I;
    end
    if (WR_I && ADDR_I == `VIH_OFF_PCLR_HI) begin
      pend_nxt[14:8] = pend_nxt[14:8] & ~WDATA_I[6:0];
    end
    if (WR_I && ADDR_I == `VIH_OFF_PSET_LO) begin
      pend_nxt[7:0] = pend_nxt[7:0] | WDATA_I;                       // [R14]
    end
    if (WR_I && ADDR_I == `VIH_OFF_PSET_HI) begin
      pend_nxt[14:8] = pend_nxt[14:8] | WDATA_I[6:0];
    end
    pend_nxt = pend_nxt | SRC_EVT_I;                                 // [R02] [R03]
    pend_nxt = pend_nxt & `VIH_VALID_MASK;                           // [R19]
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;                                            // [R11]
    end
  end

  // In-service levels, pushed on call and popped on return
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (grant) begin
      if (req_hi_r) begin
        act_hi_r <= 1'b1;                                            // [R15]
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (RETURN_FROM_INTERRUPT_OP_I) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0;                                            // [R05]
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  // Forced call sequence, four cycles of call strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r     <= VIH_IDLE;
      call_cnt_r  <= 3'h0;
      call_r      <= 1'b0;
      call_addr_r <= 16'h0000;
      last_idx_r  <= 4'h0;
    end else begin
      unique case (state_r)
        VIH_IDLE: begin
          if (grant) begin
            state_r     <= VIH_CALL;
            call_cnt_r  <= `VIH_CALL_CYC - 3'h1;                     // [R17]
            call_r      <= 1'b1;
            call_addr_r <= `VIH_VEC_BASE
                           + ({12'h000, req_idx_r} << `VIH_VEC_SHIFT); // [R04]
            last_idx_r  <= req_idx_r;
          end
        end
        VIH_CALL: begin
          if (call_cnt_r == 3'h0) begin
            state_r <= VIH_IDLE;
            call_r  <= 1'b0;
          end else begin
            call_cnt_r <= call_cnt_r - 3'h1;
          end
        end
      endcase
    end
  end

  // Event status, write one to clear, new events win
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (WR_I && ADDR_I == `VIH_OFF_EVT_STAT) begin
      evt_stat_nxt = evt_stat_nxt & ~WDATA_I[2:0];
    end
    if (grant) begin
      evt_stat_nxt[`VIH_EVT_LO_BIT]  = evt_stat_nxt[`VIH_EVT_LO_BIT] | !req_hi_r;
      evt_stat_nxt[`VIH_EVT_HI_BIT]  = evt_stat_nxt[`VIH_EVT_HI_BIT] | req_hi_r;
      evt_stat_nxt[`VIH_EVT_PRE_BIT] = evt_stat_nxt[`VIH_EVT_PRE_BIT]
                                       | (req_hi_r & act_lo_r);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      evt_stat_r <= `VIH_RST_EVT;
      evt_mask_r <= `VIH_RST_EVT;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      if (WR_I && ADDR_I == `VIH_OFF_EVT_MASK) begin
        evt_mask_r <= WDATA_I[2:0];
      end
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_r <= 8'h00;
    end else if (RD_I) begin
      unique case (ADDR_I)
        `VIH_OFF_PRI_EN:   rdata_r <= pri_en_r;
        `VIH_OFF_EXT_EN:   rdata_r <= ext_en_r;
        `VIH_OFF_PRI_PRIO: rdata_r <= pri_prio_r;
        `VIH_OFF_EXT_PRIO: rdata_r <= ext_prio_r;
        `VIH_OFF_PSET_LO:  rdata_r <= pend_r[7:0];
        `VIH_OFF_PSET_HI:  rdata_r <= {1'b0, pend_r[14:8]};
        `VIH_OFF_EVT_STAT: rdata_r <= {5'h00, evt_stat_r};
        `VIH_OFF_EVT_MASK: rdata_r <= {5'h00, evt_mask_r};
        `VIH_OFF_SVC_STAT: rdata_r <= {act_hi_r, act_lo_r, call_r, 1'b0, last_idx_r};
        default:           rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign RDATA_O     = rdata_r;
  assign CALL_O      = call_r;
  assign CALL_ADDR_O = call_addr_r;
  assign PEND_O      = pend_r;
  assign IRQ_O       = |(evt_stat_r & evt_mask_r);

  call_length_a: assert property ( // [R17]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> call_r [*4] ##1 !call_r)
    else $error("forced call strobe not four cycles");

  global_gate_a: assert property ( // [R10]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> $past(glb, 2) && $past(glb))
    else $error("call launched with global enable off");

  call_timing_a: assert property ( // [R04]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> $past(INSTR_DONE_I) && !$past(RETURN_FROM_INTERRUPT_OP_I)
                      && (call_addr_r == `VIH_VEC_BASE
                          + ({12'h000, last_idx_r} << `VIH_VEC_SHIFT)))
    else $error("call not at instruction end or wrong vector");

  enable_gate_a: assert property ( // [R07]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> ($past(en_slots) & vih_slot_bit(last_idx_r)) != '0)
    else $error("call for a disabled source");

  high_no_preempt_a: assert property ( // [R15]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> !$past(act_hi_r) && (!$past(act_lo_r) || act_hi_r))
    else $error("illegal preemption");

  flag_set_a: assert property ( // [R02]
    @(posedge CLK_I) disable iff (RST_I)
    ((SRC_EVT_I & `VIH_VALID_MASK) != '0)
    |=> ((pend_r & $past(SRC_EVT_I & `VIH_VALID_MASK))
         == $past(SRC_EVT_I & `VIH_VALID_MASK)))
    else $error("source event lost");

  held_pending_a: assert property ( // [R11]
    @(posedge CLK_I) disable iff (RST_I)
    !glb && !pclr_wr |=> (($past(pend_r) & ~pend_r) == '0))
    else $error("pending flag dropped while disabled");

  soft_set_a: assert property ( // [R14]
    @(posedge CLK_I) disable iff (RST_I)
    WR_I && ADDR_I == `VIH_OFF_PSET_LO
    |=> ((pend_r[7:0] & $past(WDATA_I)) == $past(WDATA_I)))
    else $error("software set of pending flag lost");

  reserved_slot_a: assert property ( // [R19]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) |-> ((vih_slot_bit(last_idx_r) & `VIH_VALID_MASK) != '0)
                      && ((pend_r & ~`VIH_VALID_MASK) == '0))
    else $error("reserved slot flagged or vectored");

  hw_clear_a: assert property ( // [R12]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r) && ((vih_slot_bit(last_idx_r) & `VIH_HWCLR_MASK) != '0)
    && !$past(WR_I) && (($past(SRC_EVT_I) & vih_slot_bit(last_idx_r)) == '0)
    |-> ((pend_r & vih_slot_bit(last_idx_r)) == '0))
    else $error("hardware-cleared flag still set after vectoring");

  detect_first_a: assert property ( // [R17]
    @(posedge CLK_I) disable iff (RST_I)
    $rose(call_r)
    |-> (($past(pend_r, 2) & vih_slot_bit(last_idx_r)) != '0))
    else $error("call without a detected pending flag");

  return_pop_a: assert property ( // [R05]
    @(posedge CLK_I) disable iff (RST_I)
    RETURN_FROM_INTERRUPT_OP_I
    |=> !act_hi_r && (act_lo_r == ($past(act_lo_r) && $past(act_hi_r))))
    else $error("return did not pop the active level");

  addr_hold_a: assert property ( // [R04]
    @(posedge CLK_I) disable iff (RST_I)
    call_r && !$rose(call_r) |-> $stable(call_addr_r))
    else $error("routine address changed during the call");

  global_off_a: assert property ( // [R10]
    @(posedge CLK_I) disable iff (RST_I)
    !glb |-> !arb_valid)
    else $error("request raised with global enable off");

  arb_enabled_a: assert property ( // [R07]
    @(posedge CLK_I) disable iff (RST_I)
    arb_valid |-> ((en_slots & pend_r & vih_slot_bit(arb_idx)) != '0))
    else $error("request for a disabled or idle source");

  prio_first_a: assert property ( // [R16]
    @(posedge CLK_I) disable iff (RST_I)
    arb_valid && !arb_hi
    |-> ((pend_r & en_slots & prio_slots) == '0))
    else $error("low request chosen over a high one");

  lo_busy_a: assert property ( // [R18]
    @(posedge CLK_I) disable iff (RST_I)
    act_lo_r && arb_valid |-> arb_hi)
    else $error("low request during a low routine");
endmodule : vih_top

// file: verif/vih_cpu_model.sv
// CPU sequencer model: instruction boundaries and return-from-interrupt
`timescale 1ns/1ps
module vih_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic call_i,
  input  wire logic slow_i,
  input  wire logic ret_req_i,
  output logic      instr_done_o,
  output logic      return_from_interrupt_op_o
);
  logic [1:0] cnt_r;
  logic       ret_pend_r;
  logic [1:0] lim;

  assign lim = slow_i ? 2'h2 : 2'h0;

  always_ff @(posedge clk_i) begin
    instr_done_o <= 1'b0;
    return_from_interrupt_op_o       <= 1'b0;
    if (rst_i) begin
      cnt_r      <= 2'h0;
      ret_pend_r <= 1'b0;
    end else begin
      if (ret_req_i) begin
        ret_pend_r <= 1'b1;
      end
      if (call_i) begin
        cnt_r <= 2'h0; // No instruction ends in the forced call after its first cycle
      end else if (cnt_r >= lim) begin
        cnt_r <= 2'h0;
        if (ret_pend_r) begin
          return_from_interrupt_op_o     <= 1'b1; // Routine ends with the return op
          ret_pend_r <= 1'b0;
        end else begin
          instr_done_o <= 1'b1; // Instruction boundary
        end
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end
endmodule : vih_cpu_model

// file: verif/vih_top_tb.sv
// Self-checking testbench of the vectored interrupt handler
`timescale 1ns/1ps
module vih_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [14:0] evt = 15'h0000;
  logic        done;
  logic        return_from_interrupt_op;
  logic        call;
  logic [15:0] call_addr;
  logic [14:0] pend;
  logic        irq;
  logic        slow = 1'b0;
  logic        ret_req = 1'b0;
  int          n_fail = 0;
  int          num_checks = 0;

  always #2 clk = ~clk;

  vih_top i_vih_top (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SRC_EVT_I(evt), .INSTR_DONE_I(done), .RETURN_FROM_INTERRUPT_OP_I(return_from_interrupt_op),
    .CALL_O(call), .CALL_ADDR_O(call_addr), .PEND_O(pend), .IRQ_O(irq));

  vih_cpu_model i_vih_cpu_model (.clk_i(clk), .rst_i(rst), .call_i(call), .slow_i(slow),
    .ret_req_i(ret_req), .instr_done_o(done), .return_from_interrupt_op_o(return_from_interrupt_op));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rchk

  task automatic ev(input logic [14:0] m);
    evt <= m;
    @(posedge clk);
    evt <= 15'h0000;
    @(posedge clk);
  endtask : ev

  task automatic no_call(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (call !== 1'b0) seen = 1'b1;
    end
    chk({15'h0000, seen}, 16'h0000);
  endtask : no_call

  // Vector address and four-cycle call length
  task automatic wait_call(input logic [3:0] slot);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(call_addr, 16'h0003 + {9'h000, slot, 3'h0});
    n = 0;
    while (call === 1'b1 && n < 9) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n), 16'h0004);
  endtask : wait_call

  task automatic ret();
    int n;
    n = 0;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    while (return_from_interrupt_op !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk({15'h0000, return_from_interrupt_op}, 16'h0001);
  endtask : ret

  task automatic t_reset();
    chk({1'b0, pend}, 16'h0000);
    chk(call_addr, 16'h0000);
    for (int a = 0; a <= 10; a++) rchk(8'(a), 8'h00);
    wreg(8'h20, 8'hFF);
    rchk(8'h20, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_global();
    ev(15'h0002);
    chk({1'b0, pend}, 16'h0002);
    no_call(10);
    wreg(8'h00, 8'h02);
    no_call(10);
    wreg(8'h00, 8'h82);
    wait_call(4'h1);
    chk({1'b0, pend}, 16'h0000);
    ret();
    no_call(10);
    $display("t_global done");
  endtask : t_global

  task automatic t_soft();
    wreg(8'h00, 8'h90);
    wreg(8'h04, 8'h10);
    wait_call(4'h4);
    chk({1'b0, pend}, 16'h0010);
    ret();
    wait_call(4'h4);
    wreg(8'h06, 8'h10);
    ret();
    no_call(10);
    $display("t_soft done");
  endtask : t_soft

  task automatic t_prio();
    slow <= 1'b1;
    wreg(8'h00, 8'hE4);
    wreg(8'h01, 8'h20);
    wreg(8'h03, 8'h20);
    wreg(8'h02, 8'h40);
    ev(15'h0024);
    wait_call(4'h2);
    no_call(10);
    ev(15'h1000);
    wait_call(4'hC);
    wreg(8'h07, 8'h10);
    ev(15'h0040);
    no_call(10);
    ret();
    wait_call(4'h6);
    wreg(8'h06, 8'h40);
    ret();
    no_call(10);
    ret();
    wait_call(4'h5);
    wreg(8'h06, 8'h20);
    ret();
    no_call(10);
    wreg(8'h00, 8'h00);
    slow <= 1'b0;
    $display("t_prio done");
  endtask : t_prio

  task automatic t_reserved();
    wreg(8'h05, 8'h7F);
    ev(15'h2300);
    chk({1'b0, pend}, 16'h5C00);
    rchk(8'h05, 8'h5C);
    wreg(8'h07, 8'h7F);
    wreg(8'h00, 8'h80);
    wreg(8'h01, 8'hFF);
    ev(15'h2300);
    no_call(10);
    wreg(8'h00, 8'h00);
    $display("t_reserved done");
  endtask : t_reserved

  task automatic t_irq();
    rchk(8'h08, 8'h07);
    chk({15'h0000, irq}, 16'h0000);
    wreg(8'h09, 8'h04);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    wreg(8'h08, 8'h04);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rchk(8'h08, 8'h03);
    $display("t_irq done");
  endtask : t_irq

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_global();
    t_soft();
    t_prio();
    t_reserved();
    t_irq();
    wrap_up();
  end

  // Watchdog sized well above the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule : vih_top_tb
